// ===== design/vfp_palette_regs.sv
`timescale 1ns/10ps
`include "vfp_params.svh"
module vfp_palette_regs
	import vfp_pkg::*;
(
	input wire logic clock,
	input wire logic srst,
	input wire logic [15:0] io_addr,
	input wire logic io_wr,
	input wire logic io_rd,
	input wire logic [7:0] io_wdata,
	output logic [7:0] io_rdata,
	output logic io_hit,
	input wire logic vsync_in,
	input wire logic active_video_in,
	input wire logic [7:0] pixel_index,
	input wire logic pixel_code_high,
	input wire logic pixel_code_low,
	output vfp_rgb_t pixel_rgb,
	output vfp_mode_t mode_out,
	output logic [3:0] mode_number
);
	logic [7:0] mask_r;
	logic [7:0] mode_r;
	logic [7:0] border_select_reg;
	logic [7:0] ext_r;
	logic [7:0] wr_ptr_r;
	logic [7:0] rd_ptr_r;
	vfp_phase_t wr_phase_r;
	vfp_phase_t rd_phase_r;
	logic [1:0] last_cmd_r;
	logic [5:0] red_hold_r;
	logic [5:0] green_hold_r;
	vfp_rgb_t pal_mem [0:255];
	vfp_rgb_t rd_word;
	logic [2:0] vs_sync_r;
	logic [2:0] av_sync_r;
	logic vs_r;
	logic av_r;
	logic wr_mask, wr_mode, wr_border, wr_ext, wr_rdptr, wr_wrptr, wr_data, rd_data;
	logic [7:0] pal_sel_nxt;
	logic [7:0] pal_sel_r;
	logic [7:0] io_rdata_nxt;

	assign wr_mask = io_wr && io_addr == `VFP_ADDR_MASK;
	assign wr_rdptr = io_wr && io_addr == `VFP_ADDR_RDPTR;
	assign wr_wrptr = io_wr && io_addr == `VFP_ADDR_WRPTR;
	assign wr_data = io_wr && io_addr == `VFP_ADDR_DATA;
	assign rd_data = io_rd && io_addr == `VFP_ADDR_DATA;
	assign wr_mode = io_wr && io_addr == `VFP_ADDR_MODE;
	assign wr_border = io_wr && io_addr == `VFP_ADDR_BORDER;
	assign wr_ext = io_wr && io_addr == `VFP_ADDR_EXT;

	// control registers
	always_ff @(posedge clock) begin
		if (srst) begin
			mask_r <= `VFP_RST_MASK;
			mode_r <= `VFP_RST_MODE;
			border_select_reg <= `VFP_RST_BORDER;
			ext_r <= `VFP_RST_EXT;
		end else begin
			if (wr_mask)
				mask_r <= io_wdata;
			if (wr_mode)
				mode_r <= {2'b00, io_wdata[5:0]};
			if (wr_border)
				border_select_reg <= {2'b00, io_wdata[5:0]};
			if (wr_ext)
				ext_r <= {5'b00000, io_wdata[`VFP_EXT_256], 2'b00};
		end
	end

	// status pins through three flops, then a flop that loads only when the last two samples agree
	always_ff @(posedge clock) begin
		if (srst) begin
			vs_sync_r <= 3'h0;
			av_sync_r <= 3'h0;
			vs_r <= 1'b0;
			av_r <= 1'b0;
		end else begin
			vs_sync_r <= {vs_sync_r[1:0], vsync_in};
			av_sync_r <= {av_sync_r[1:0], active_video_in};
			if (vs_sync_r[2] == vs_sync_r[1])
				vs_r <= vs_sync_r[2];
			if (av_sync_r[2] == av_sync_r[1])
				av_r <= av_sync_r[2];
		end
	end

	// write pointer and red, green, blue sequence
	always_ff @(posedge clock) begin
		if (srst) begin
			wr_ptr_r <= 8'h00;
			wr_phase_r <= VFP_RED;
			red_hold_r <= 6'h00;
			green_hold_r <= 6'h00;
		end else if (wr_wrptr) begin
			wr_ptr_r <= io_wdata;
			wr_phase_r <= VFP_RED;
		end else if (wr_data) begin
			case (wr_phase_r)
				VFP_RED: begin
					red_hold_r <= io_wdata[5:0];
					wr_phase_r <= VFP_GREEN;
				end
				VFP_GREEN: begin
					green_hold_r <= io_wdata[5:0];
					wr_phase_r <= VFP_BLUE;
				end
				VFP_BLUE: begin
					wr_ptr_r <= wr_ptr_r + 8'h01;
					wr_phase_r <= VFP_RED;
				end
				default: begin
					wr_phase_r <= VFP_RED;
				end
			endcase
		end
	end

	// palette storage
	always_ff @(posedge clock) begin
		if (wr_data && wr_phase_r == VFP_BLUE && !wr_wrptr)
			pal_mem[wr_ptr_r] <= '{red: red_hold_r, green: green_hold_r,
				blue: io_wdata[5:0]};
	end

	// read pointer and sequence
	always_ff @(posedge clock) begin
		if (srst) begin
			rd_ptr_r <= 8'h00;
			rd_phase_r <= VFP_RED;
		end else if (wr_rdptr) begin
			rd_ptr_r <= io_wdata;
			rd_phase_r <= VFP_RED;
		end else if (rd_data) begin
			case (rd_phase_r)
				VFP_RED: rd_phase_r <= VFP_GREEN;
				VFP_GREEN: rd_phase_r <= VFP_BLUE;
				VFP_BLUE: begin
					rd_ptr_r <= rd_ptr_r + 8'h01;
					rd_phase_r <= VFP_RED;
				end
				default: rd_phase_r <= VFP_RED;
			endcase
		end
	end

	// last palette command
	always_ff @(posedge clock) begin
		if (srst)
			last_cmd_r <= `VFP_CMD_WRITE;
		else if (wr_rdptr)
			last_cmd_r <= `VFP_CMD_READ;
		else if (wr_wrptr)
			last_cmd_r <= `VFP_CMD_WRITE;
	end

	assign rd_word = pal_mem[rd_ptr_r];

	// read mux
	always_comb begin
		io_rdata_nxt = 8'h00;
		case (io_addr)
			`VFP_ADDR_MASK: io_rdata_nxt = mask_r;
			`VFP_ADDR_RDPTR: io_rdata_nxt = {6'h00, last_cmd_r};
			`VFP_ADDR_WRPTR: io_rdata_nxt = wr_ptr_r;
			`VFP_ADDR_DATA: begin
				case (rd_phase_r)
					VFP_RED: io_rdata_nxt = {2'b00, rd_word.red};
					VFP_GREEN: io_rdata_nxt = {2'b00, rd_word.green};
					default: io_rdata_nxt = {2'b00, rd_word.blue};
				endcase
			end
			`VFP_ADDR_MODE: io_rdata_nxt = mode_r;
			`VFP_ADDR_BORDER: io_rdata_nxt = border_select_reg;
			`VFP_ADDR_STATUS: begin
				io_rdata_nxt[`VFP_STAT_VSYNC] = vs_r;
				io_rdata_nxt[`VFP_STAT_NDISP] = ~av_r;
			end
			`VFP_ADDR_EXT: begin
				io_rdata_nxt = ext_r;
				io_rdata_nxt[`VFP_EXT_NORD] = 1'b0;
			end
			default: io_rdata_nxt = 8'h00;
		endcase
	end

	always_ff @(posedge clock) begin
		if (srst) begin
			io_rdata <= 8'h00;
			io_hit <= 1'b0;
		end else begin
			io_rdata <= io_rdata_nxt;
			io_hit <= io_rd && (io_addr == `VFP_ADDR_MASK || io_addr == `VFP_ADDR_RDPTR
				|| io_addr == `VFP_ADDR_WRPTR || io_addr == `VFP_ADDR_DATA
				|| io_addr == `VFP_ADDR_MODE || io_addr == `VFP_ADDR_BORDER
				|| io_addr == `VFP_ADDR_STATUS || io_addr == `VFP_ADDR_EXT);
		end
	end

	// mode decode
	always_ff @(posedge clock) begin
		if (srst) begin
			mode_out <= '0;
			mode_number <= 4'h0;
		end else begin
			mode_out.blink_en <= mode_r[`VFP_MODE_BLINK];
			mode_out.hires_mono <= mode_r[`VFP_MODE_HIRES];
			mode_out.video_en <= mode_r[`VFP_MODE_VIDEO];
			mode_out.bw_sel <= mode_r[`VFP_MODE_BW];
			mode_out.gfx_320 <= mode_r[`VFP_MODE_GFX];
			mode_out.text_80 <= mode_r[`VFP_MODE_TEXT80];
			mode_out.mode_256 <= ext_r[`VFP_EXT_256];
			if (ext_r[`VFP_EXT_256])
				mode_number <= 4'hD;
			else if (mode_r[`VFP_MODE_HIRES])
				mode_number <= 4'h6;
			else if (mode_r[`VFP_MODE_GFX])
				mode_number <= 4'h4;
			else if (mode_r[`VFP_MODE_TEXT80])
				mode_number <= 4'h3;
			else
				mode_number <= 4'h1;
		end
	end

	// colour index selection
	always_comb begin
		pal_sel_nxt = pixel_index;
		if (ext_r[`VFP_EXT_256])
			pal_sel_nxt = pixel_index;
		else if (mode_r[`VFP_MODE_HIRES]) begin
			if (!pixel_code_low)
				pal_sel_nxt = 8'h00;
			else if (mode_r[`VFP_MODE_BW])
				pal_sel_nxt = `VFP_IDX_WHITE;
			else
				pal_sel_nxt = {4'h0, border_select_reg[3:0]};
		end else if (mode_r[`VFP_MODE_GFX]) begin
			if (!pixel_code_high && !pixel_code_low)
				pal_sel_nxt = {4'h0, border_select_reg[3:0]};
			else
				pal_sel_nxt = {4'h0, border_select_reg[`VFP_BRD_INT], pixel_code_high,
					pixel_code_low, border_select_reg[`VFP_BRD_SET]};
		end else if (!mode_r[`VFP_MODE_BLINK])
			pal_sel_nxt = {4'h0, pixel_index[3:0]};
		else
			pal_sel_nxt = {5'h00, pixel_index[2:0]};
	end

	always_ff @(posedge clock) begin
		if (srst)
			pal_sel_r <= 8'h00;
		else
			pal_sel_r <= pal_sel_nxt;
	end

	always_ff @(posedge clock) begin
		if (srst)
			pixel_rgb <= '0;
		else if (!mode_r[`VFP_MODE_VIDEO])
			pixel_rgb <= '0;
		else
			pixel_rgb <= pal_mem[pal_sel_r];
	end
endmodule : vfp_palette_regs

// ===== design/vfp_params.svh
`ifndef VFP_PARAMS_SVH
`define VFP_PARAMS_SVH
`define VFP_ADDR_MASK 16'h03C6
`define VFP_ADDR_RDPTR 16'h03C7
`define VFP_ADDR_WRPTR 16'h03C8
`define VFP_ADDR_DATA 16'h03C9
`define VFP_ADDR_MODE 16'h03D8
`define VFP_ADDR_BORDER 16'h03D9
`define VFP_ADDR_STATUS 16'h03DA
`define VFP_ADDR_EXT 16'h03DD
`define VFP_MODE_BLINK 5
`define VFP_MODE_HIRES 4
`define VFP_MODE_VIDEO 3
`define VFP_MODE_BW 2
`define VFP_MODE_GFX 1
`define VFP_MODE_TEXT80 0
`define VFP_BRD_SET 5
`define VFP_BRD_INT 4
`define VFP_STAT_VSYNC 3
`define VFP_STAT_NDISP 0
`define VFP_EXT_NORD 7
`define VFP_EXT_256 2
`define VFP_RST_MASK 8'hFF
`define VFP_RST_MODE 8'h00
`define VFP_RST_BORDER 8'h30
`define VFP_RST_EXT 8'h00
`define VFP_CMD_WRITE 2'h0
`define VFP_CMD_READ 2'h3
`define VFP_IDX_WHITE 8'h07
`endif

// ===== design/vfp_pkg.sv
package vfp_pkg;
	typedef enum logic [1:0] {VFP_RED, VFP_GREEN, VFP_BLUE} vfp_phase_t;
	typedef struct packed {
		logic [5:0] red;
		logic [5:0] green;
		logic [5:0] blue;
	} vfp_rgb_t;
	typedef struct packed {
		logic blink_en;
		logic hires_mono;
		logic video_en;
		logic bw_sel;
		logic gfx_320;
		logic text_80;
		logic mode_256;
	} vfp_mode_t;
endpackage : vfp_pkg

// ===== testbench/vfp_host_model.sv
`timescale 1ns/10ps
module vfp_host_model (
	input logic clock,
	input logic [7:0] io_rdata,
	output logic [15:0] io_addr = 16'h0000,
	output logic [7:0] io_wdata = 8'h00,
	output logic io_wr = 1'b0,
	output logic io_rd = 1'b0
);
	// one port cycle, address and data parked on inverted values after, io_wr and io_rd low
	task automatic acc(input logic w, input logic [15:0] a, input logic [7:0] x,
		output logic [7:0] q);
		@(posedge clock);
		#1;
		{io_addr, io_wdata, io_wr, io_rd} = {a, x, w, !w};
		@(posedge clock);
		#1;
		{io_addr, io_wdata, io_wr, io_rd} = {~a, ~x, 2'h0};
		q = io_rdata;
	endtask : acc
endmodule : vfp_host_model

// ===== testbench/vfp_palette_regs_assertions.sv
`timescale 1ns/10ps
`include "vfp_params.svh"
module vfp_palette_regs_assertions
	import vfp_pkg::*;
(
	input logic clock,
	input logic srst,
	input logic [15:0] io_addr,
	input logic io_wr,
	input logic io_rd,
	input logic [7:0] io_wdata,
	input logic [7:0] io_rdata,
	input logic io_hit,
	input logic vsync_in,
	input logic active_video_in,
	input vfp_rgb_t pixel_rgb,
	input vfp_mode_t mode_out
);
	default clocking @(posedge clock); endclocking
	default disable iff (srst);
	property p_hit;
		io_rd && io_addr == `VFP_ADDR_DATA |=> io_hit && io_rdata[7:6] == 2'h0;
	endproperty
	a_hit: assert property (p_hit) else $error("data read");
	property p_nohit;
		!io_rd || io_addr == 16'h03DB |=> !io_hit;
	endproperty
	a_nohit: assert property (p_nohit) else $error("stray hit");
	property p_vsync;
		vsync_in [*6] ##0 io_addr == `VFP_ADDR_STATUS |=> io_rdata[3];
	endproperty
	a_vsync: assert property (p_vsync) else $error("vsync bit");
	property p_disp;
		active_video_in [*6] ##0 io_addr == `VFP_ADDR_STATUS |=> !io_rdata[0];
	endproperty
	a_disp: assert property (p_disp) else $error("display bit");
	property p_ext;
		io_wr && io_addr == `VFP_ADDR_EXT ##1 !io_wr ##1 io_rd && io_addr == `VFP_ADDR_EXT
			|=> !io_rdata[7] && io_rdata[2] == $past(io_wdata[2], 3);
	endproperty
	a_ext: assert property (p_ext) else $error("ext mode");
	property p_cmd;
		io_wr && (io_addr == `VFP_ADDR_RDPTR || io_addr == `VFP_ADDR_WRPTR) ##1 !io_wr
			##1 io_rd && io_addr == `VFP_ADDR_RDPTR |=> io_rdata[1:0] == {2{$past(io_addr[0], 3)}};
	endproperty
	a_cmd: assert property (p_cmd) else $error("last command");
	property p_mode;
		io_wr && io_addr == `VFP_ADDR_MODE ##1 !io_wr |=> mode_out[6:1] == $past(io_wdata[5:0], 2);
	endproperty
	a_mode: assert property (p_mode) else $error("mode bits");
	property p_blank;
		!mode_out.video_en [*4] |-> pixel_rgb == 18'h0;
	endproperty
	a_blank: assert property (p_blank) else $error("not blanked");
	c_hit: cover property (io_hit);
	c_vid: cover property (mode_out.video_en && pixel_rgb != 18'h0);
	c_wrap: cover property (io_wr && io_wdata == 8'hFE);
endmodule : vfp_palette_regs_assertions
bind vfp_palette_regs vfp_palette_regs_assertions u_chk (.clock, .srst, .io_addr, .io_wr, .io_rd,
	.io_wdata, .io_rdata, .io_hit, .vsync_in, .active_video_in, .pixel_rgb, .mode_out);

// ===== testbench/vfp_palette_regs_tb_top.sv
`timescale 1ns/10ps
`include "vfp_params.svh"
module vfp_palette_regs_tb_top
	import vfp_pkg::*;
;
	logic clock = 1'b0;
	logic srst = 1'b1;
	logic [15:0] io_addr;
	logic [7:0] io_wdata, io_rdata, d, v;
	logic io_wr, io_rd, io_hit, vsync_in = 1'b0, active_video_in = 1'b0;
	logic [7:0] pixel_index = 8'h00;
	logic pixel_code_high = 1'b0, pixel_code_low = 1'b0;
	logic [3:0] mode_number;
	vfp_rgb_t pixel_rgb, pal [256];
	vfp_mode_t mode_out;
	int seed = 32'h4957, err_total = 0, total_checks = 0, cyc = 0;
	vfp_palette_regs DUT (.clock, .srst, .io_addr, .io_wr, .io_rd, .io_wdata, .io_rdata, .io_hit,
		.vsync_in, .active_video_in, .pixel_index, .pixel_code_high, .pixel_code_low,
		.pixel_rgb, .mode_out, .mode_number);
	vfp_host_model host (.clock, .io_rdata, .io_addr, .io_wdata, .io_wr, .io_rd);
	always #2 clock = ~clock;
	task automatic chk(input logic [17:0] got, input logic [17:0] exp);
		total_checks++;
		if (got !== exp) begin
			err_total++;
			$display("Error %0t: got %h exp %h", $time, got, exp);
		end
	endtask : chk
	task automatic test_done();
		$display("checks %0d errors %0d", total_checks, err_total);
		if (err_total == 0 && total_checks > 0) $display("TEST PASSED");
		else $display("TEST FAILED");
		$finish;
	endtask : test_done
	always @(posedge clock) begin
		cyc++;
		if (cyc % 8 == 0) #1 {vsync_in, active_video_in} = 2'($random(seed));
		if (cyc == 4000) begin
			err_total++;
			test_done();
		end
	end
	function automatic logic [7:0] px_addr(input logic [7:0] b, input logic [1:0] c);
		return (c == 2'h0) ? {4'h0, b[3:0]} : {4'h0, b[4], c, b[5]};
	endfunction : px_addr
	// burst write or read of n entries from s
	task automatic burst(input logic [7:0] s, input int n, input logic rb);
		host.acc(1'b1, rb ? `VFP_ADDR_RDPTR : `VFP_ADDR_WRPTR, s, v);
		for (int i = 0; i < n; i++) begin
			if (!rb) pal[8'(s + i)] = 18'($random(seed));
			for (int k = 2; k >= 0; k--) begin
				host.acc(!rb, `VFP_ADDR_DATA, {2'h0, pal[8'(s + i)][6*k +: 6]}, d);
				if (rb) chk(18'(d), 18'(pal[8'(s + i)][6*k +: 6]));
			end
		end
	endtask : burst
	initial begin
		repeat (4) @(posedge clock);
		#1 srst = 1'b0;
		host.acc(1'b0, `VFP_ADDR_MASK, 8'h00, d);
		chk(18'(d), 18'hFF);
		host.acc(1'b0, `VFP_ADDR_BORDER, 8'h00, d);
		chk(18'(d), 18'h30);
		host.acc(1'b1, `VFP_ADDR_EXT, 8'hFF, d);
		host.acc(1'b0, `VFP_ADDR_EXT, 8'h00, d);
		chk(18'(d), 18'h04);
		for (int i = 0; i < 8; i++) begin
			v = 8'($random(seed));
			host.acc(1'b1, i[0] ? `VFP_ADDR_MODE : `VFP_ADDR_BORDER, v, d);
			host.acc(1'b0, i[0] ? `VFP_ADDR_MODE : `VFP_ADDR_BORDER, 8'h00, d);
			chk(18'(d), 18'(v & 8'h3F));
		end
		host.acc(1'b1, `VFP_ADDR_EXT, 8'h00, d);
		repeat (24) host.acc(1'b0, `VFP_ADDR_STATUS, 8'h00, d);
		host.acc(1'b0, 16'h03DB, 8'h00, d);
		chk(18'(d), 18'h0);
		$display("register test done");
		burst(8'h00, 16, 1'b0);
		burst(8'hFE, 3, 1'b0);
		burst(8'hFE, 3, 1'b1);
		burst(8'h00, 16, 1'b1);
		host.acc(1'b0, `VFP_ADDR_RDPTR, 8'h00, d);
		chk(18'(d[1:0]), 18'h3);
		host.acc(1'b1, `VFP_ADDR_WRPTR, 8'h00, d);
		host.acc(1'b0, `VFP_ADDR_RDPTR, 8'h00, d);
		chk(18'(d[1:0]), 18'h0);
		host.acc(1'b1, `VFP_ADDR_MODE, 8'h0A, d);
		for (int i = 0; i < 16; i++) begin
			v = 8'($random(seed));
			host.acc(1'b1, `VFP_ADDR_BORDER, v, d);
			{pixel_code_high, pixel_code_low, pixel_index} = 10'($random(seed));
			repeat (2) @(posedge clock);
			#1 chk(pixel_rgb, pal[px_addr(v, {pixel_code_high, pixel_code_low})]);
		end
		chk(18'(mode_number), 18'h4);
		host.acc(1'b1, `VFP_ADDR_MODE, 8'h18, d);
		pixel_code_low = 1'b1;
		repeat (4) @(posedge clock);
		#1 chk(pixel_rgb, pal[{4'h0, v[3:0]}]);
		chk(18'(mode_number), 18'h6);
		host.acc(1'b1, `VFP_ADDR_MODE, 8'h09, d);
		pixel_index = 8'($random(seed));
		repeat (2) @(posedge clock);
		#1 chk(pixel_rgb, pal[{4'h0, pixel_index[3:0]}]);
		chk(18'(mode_number), 18'h3);
		host.acc(1'b1, `VFP_ADDR_MODE, 8'h28, d);
		repeat (2) @(posedge clock);
		#1 chk(pixel_rgb, pal[{5'h00, pixel_index[2:0]}]);
		host.acc(1'b1, `VFP_ADDR_EXT, 8'h04, d);
		pixel_index = 8'hFE;
		repeat (2) @(posedge clock);
		#1 chk(pixel_rgb, pal[8'hFE]);
		chk(18'(mode_number), 18'hD);
		host.acc(1'b1, `VFP_ADDR_EXT, 8'h00, d);
		host.acc(1'b1, `VFP_ADDR_MODE, 8'h02, d);
		repeat (4) @(posedge clock);
		#1 chk(pixel_rgb, 18'h0);
		$display("pixel test done");
		test_done();
	end
endmodule : vfp_palette_regs_tb_top
